// ===== rtl/iptc_pkg.sv
`default_nettype none
package iptc_pkg;
  // ***********************************************************
  // Register map (byte addresses; printed offsets not all word aligned)
  // ***********************************************************
  localparam logic [7:0] IDX_RUN   = 8'h0C;
  localparam logic [7:0] IDX_WAVE  = 8'h0E;
  localparam logic [7:0] IDX_FLAGS = 8'h0F;
  localparam logic [7:0] IDX_MASK  = 8'h10;
  localparam logic [7:0] IDX_PRE0  = 8'h11;
  localparam logic [7:0] IDX_SCALE = 8'h15;
  localparam logic [7:0] IDX_PORT5 = 8'h16;
  localparam int         ADDR_W    = 12;
  localparam logic [ADDR_W-1:0] ADDR_RUN   = ADDR_W'({IDX_RUN, 2'b00});
  localparam logic [ADDR_W-1:0] ADDR_WAVE  = ADDR_W'({IDX_WAVE, 2'b00});
  localparam logic [ADDR_W-1:0] ADDR_FLAGS = ADDR_W'({IDX_FLAGS, 2'b00});
  localparam logic [ADDR_W-1:0] ADDR_MASK  = ADDR_W'({IDX_MASK, 2'b00});
  localparam logic [ADDR_W-1:0] ADDR_PRE0  = ADDR_W'({IDX_PRE0, 2'b00});
  localparam logic [ADDR_W-1:0] ADDR_SCALE = ADDR_W'({IDX_SCALE, 2'b00});
  localparam logic [ADDR_W-1:0] ADDR_PORT5 = ADDR_W'({IDX_PORT5, 2'b00});
  // ***********************************************************
  // Timer indices, run bit positions and flag positions
  // ***********************************************************
  localparam int TMR_C1 = 0;
  localparam int TMR_C2 = 1;
  localparam int TMR_HP = 2;
  localparam int TMR_LP = 3;
  localparam int NUM_TMR = 4;
  localparam int FLG_MAIN = 0;
  localparam int FLG_EXTA = 1;
  localparam int FLG_EXTB = 2;
  localparam int FLG_TMR0 = 3;
  localparam int FLG_PCHG = 7;
  localparam int WAV_EXTA = 0;
  localparam int WAV_EXTB = 1;
  localparam int WAV_TIN  = 2;
  localparam int WAV_OPIN = 3;
  localparam int WAV_LOW  = 5;
  localparam int WAV_CARR = 6;
  localparam int WAV_EN   = 7;
  localparam int P5_OUT_BIT = 7;
  localparam logic [7:0] RUN_WMASK  = 8'h0F;
  localparam logic [7:0] WAVE_WMASK = 8'hEF;
  localparam logic [7:0] RST_BYTE   = 8'h00;
  localparam logic [7:0] RST_SCALE  = 8'h00;
  localparam int PIN_SYNC = 3;
  typedef enum logic [1:0] {
    IPTC_IDLE  = 2'b00,
    IPTC_HIGH  = 2'b01,
    IPTC_LOW   = 2'b10
  } iptc_wave_t;
  typedef struct packed {
    logic       tick;
    logic       carrier;
    logic [3:0] underflow;
  } iptc_tmr_ev_t;
endpackage
`default_nettype wire

// ===== rtl/iptc_down_timer.sv
`default_nettype none
module iptc_down_timer (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       arst_n_i,
  // Control
  input  wire logic       run_i,
  input  wire logic       restart_i,
  input  wire logic [7:0] preset_i,
  input  wire logic [7:0] scale_i,
  // Events
  output logic            underflow_o,
  output logic [7:0]      count_o
);
  import iptc_pkg::*;
  logic [7:0] pre_cnt;
  logic       step;
  assign step = run_i && (pre_cnt == 8'h00);
  // Prescaler divides by scale+1; frozen while stopped so resumption is seamless
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pre_cnt <= 8'h00;
    end else if (restart_i) begin
      pre_cnt <= scale_i;
    end else if (run_i) begin
      pre_cnt <= (pre_cnt == 8'h00) ? scale_i : pre_cnt - 8'h01;
    end
  end
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      count_o     <= 8'h00;
      underflow_o <= 1'b0;
    end else begin
      underflow_o <= step && (count_o == 8'h00);
      if (restart_i) begin
        count_o <= preset_i;
      end else if (step) begin
        count_o <= (count_o == 8'h00) ? preset_i : count_o - 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

// ===== rtl/iptc_top.sv
// Overview of operation
// - Run bit 3 gates low-pulse timer
// - Run bit 2 gates high-pulse timer
// - Run bit 1 gates second counter
// - Run bit 0 gates first counter
// - Waveform enable; off follows port5 bit7
// - PWM mode: high/low from pulse timers
// - IR mode: low time carrier-modulated
// - Low-only select ignores high timer
// - Output function selects waveform pin
// - Timer input function selects clock pin
// - Second external irq pin function
// - First external irq pin function
// - Status bits set on events
// - Port 6/8 change sets bit 7
// - Pulse timer underflows set bits 6,5
// - Counter underflows set bits 4,3
// - External irq events set bits 2,1
// - Main timer overflow sets bit 0
// - 8-bit down counters auto reload
// - Mask gates flags onto request
`default_nettype none
module iptc_top (
  // Clock and reset
  input  wire logic                       CLK_I,
  input  wire logic                       ARST_N_I,
  // APB slave
  input  wire logic                       PSEL_I,
  input  wire logic                       PENABLE_I,
  input  wire logic                       PWRITE_I,
  input  wire logic [iptc_pkg::ADDR_W-1:0] PADDR_I,
  input  wire logic [31:0]                PWDATA_I,
  output logic      [31:0]                PRDATA_O,
  output logic                            PREADY_O,
  output logic                            PSLVERR_O,
  // Shared port 5 pins and external events
  input  wire logic [3:0]                 P5_PIN_I,
  input  wire logic [15:0]                P68_PIN_I,
  input  wire logic                       MAIN_TIMER_OVF_I,
  // Waveform pin and function selects
  output logic                            WAVE_PIN_O,
  output logic                            WAVE_PIN_OE_O,
  output logic                            TIMER_CLK_O,
  output logic                            TIMER_IN_SEL_O,
  output logic                            IRQ_O
);
  import iptc_pkg::*;

  // ***********************************************************
  // Registers
  // ***********************************************************
  logic [7:0]        run_reg;
  logic [7:0]        wave_reg;
  logic [7:0]        flags;
  logic [7:0]        mask;
  logic [7:0]        scale;
  logic [7:0]        port5;
  logic [7:0]        preset [NUM_TMR];
  logic [NUM_TMR-1:0] restart;
  logic [NUM_TMR-1:0] tmr_uf;
  logic [7:0]        tmr_cnt [NUM_TMR];
  logic [NUM_TMR-1:0] tmr_run;
  logic              wr_acc;
  logic              rd_acc;
  logic              mapped;
  logic [7:0]        rd_byte;
  logic [7:0]        next_flags;
  logic [7:0]        ev;

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] b);
    return a == b;
  endfunction

  // ***********************************************************
  // APB: zero wait states, unmapped addresses give PSLVERR
  // ***********************************************************
  assign wr_acc = PSEL_I && !PENABLE_I && PWRITE_I;
  assign rd_acc = PSEL_I && !PENABLE_I && !PWRITE_I;

  always_comb begin
    mapped  = 1'b1;
    rd_byte = 8'h00;
    if (hit(PADDR_I, ADDR_RUN)) begin
      rd_byte = run_reg;
    end else if (hit(PADDR_I, ADDR_WAVE)) begin
      rd_byte = wave_reg;
    end else if (hit(PADDR_I, ADDR_FLAGS)) begin
      rd_byte = flags;
    end else if (hit(PADDR_I, ADDR_MASK)) begin
      rd_byte = mask;
    end else if (hit(PADDR_I, ADDR_SCALE)) begin
      rd_byte = scale;
    end else if (hit(PADDR_I, ADDR_PORT5)) begin
      rd_byte = port5;
    end else if (PADDR_I >= ADDR_PRE0 && PADDR_I < ADDR_SCALE) begin
      rd_byte = preset[PADDR_I[3:2] - ADDR_PRE0[3:2]];
    end else begin
      mapped = 1'b0;
    end
    // Refused reads return zero, even inside the preset window
    if (PADDR_I[1:0] != 2'b00) begin
      mapped  = 1'b0;
      rd_byte = 8'h00;
    end
  end

  // Answer is registered in setup, so access phase completes in one cycle
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      PRDATA_O  <= 32'h0000_0000;
      PREADY_O  <= 1'b0;
      PSLVERR_O <= 1'b0;
    end else begin
      PREADY_O  <= wr_acc || rd_acc;
      PSLVERR_O <= PSEL_I && !PENABLE_I && !mapped;
      if (rd_acc) begin
        PRDATA_O <= {24'h00_0000, rd_byte};
      end
    end
  end

  // Write takes effect at the access edge
  logic        wr_go;
  logic [ADDR_W-1:0] wr_addr;
  assign wr_go   = PSEL_I && PENABLE_I && PWRITE_I && PREADY_O && !PSLVERR_O;
  assign wr_addr = PADDR_I;

  // unused bits dropped by write mask
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      run_reg  <= RST_BYTE;
      wave_reg <= RST_BYTE;
      mask     <= RST_BYTE;
      scale    <= RST_SCALE;
      port5    <= RST_BYTE;
    end else if (wr_go) begin
      if (hit(wr_addr, ADDR_RUN))   run_reg  <= PWDATA_I[7:0] & RUN_WMASK;
      if (hit(wr_addr, ADDR_WAVE))  wave_reg <= PWDATA_I[7:0] & WAVE_WMASK;
      if (hit(wr_addr, ADDR_MASK))  mask     <= PWDATA_I[7:0];
      if (hit(wr_addr, ADDR_SCALE)) scale    <= PWDATA_I[7:0];
      if (hit(wr_addr, ADDR_PORT5)) port5    <= PWDATA_I[7:0];
    end
  end

  // ***********************************************************
  // Timers
  // ***********************************************************
  function automatic logic [ADDR_W-1:0] pre_addr(input int i);
    return ADDR_PRE0 + ADDR_W'(4 * i);
  endfunction

  // Preset write restarts the timer from the new value
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      for (int i = 0; i < NUM_TMR; i++) begin
        preset[i] <= RST_BYTE;
      end
      restart <= '0;
    end else begin
      for (int i = 0; i < NUM_TMR; i++) begin
        restart[i] <= wr_go && hit(wr_addr, pre_addr(i));
        if (wr_go && hit(wr_addr, pre_addr(i))) begin
          preset[i] <= PWDATA_I[7:0];
        end
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < NUM_TMR; g++) begin : g_tmr
      // run bits gate and hold counters
      iptc_down_timer u_tmr (
        .clk_i       (CLK_I),
        .arst_n_i    (ARST_N_I),
        .run_i       (tmr_run[g]),
        .restart_i   (restart[g]),
        .preset_i    (preset[g]),
        .scale_i     (scale),
        .underflow_o (tmr_uf[g]),
        .count_o     (tmr_cnt[g])
      );
    end
  endgenerate

  // ***********************************************************
  // Waveform generator
  // ***********************************************************
  iptc_wave_t wstate;
  logic       carrier;
  logic       wave;
  logic       low_only;
  assign low_only = wave_reg[WAV_LOW];

  always_comb begin
    tmr_run        = run_reg[NUM_TMR-1:0];
    tmr_run[TMR_HP] = run_reg[TMR_HP] && !(wave_reg[WAV_EN] && low_only)
                      && !(wave_reg[WAV_EN] && wstate == IPTC_LOW);
    if (wave_reg[WAV_EN] && wstate == IPTC_HIGH) begin
      tmr_run[TMR_LP] = run_reg[TMR_LP] && low_only;
    end
  end

  // high then low phases from pulse timers
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      wstate <= IPTC_IDLE;
    end else begin
      case (wstate)
        IPTC_IDLE: begin
          if (wave_reg[WAV_EN]) wstate <= low_only ? IPTC_LOW : IPTC_HIGH;
        end
        IPTC_HIGH: begin
          if (!wave_reg[WAV_EN]) wstate <= IPTC_IDLE;
          else if (tmr_uf[TMR_HP] || low_only) wstate <= IPTC_LOW;
        end
        IPTC_LOW: begin
          if (!wave_reg[WAV_EN]) wstate <= IPTC_IDLE;
          else if (tmr_uf[TMR_LP] && !low_only) wstate <= IPTC_HIGH;
        end
        default: wstate <= IPTC_IDLE;
      endcase
    end
  end

  // carrier toggles on second counter underflow
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      carrier <= 1'b0;
    end else if (tmr_uf[TMR_C2]) begin
      carrier <= !carrier;
    end
  end

  // low sections modulated in IR mode
  always_comb begin
    if (wstate == IPTC_HIGH) begin
      wave = 1'b1;
    end else if (wstate == IPTC_LOW && wave_reg[WAV_CARR]) begin
      wave = carrier;
    end else if (low_only && wstate == IPTC_LOW) begin
      wave = tmr_cnt[TMR_LP][0];
    end else begin
      wave = 1'b0;
    end
  end

  // pin mux between generator and port 5 bit 7
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      WAVE_PIN_O    <= 1'b0;
      WAVE_PIN_OE_O <= 1'b0;
    end else if (wave_reg[WAV_OPIN] && wave_reg[WAV_EN]) begin
      WAVE_PIN_O    <= wave;
      WAVE_PIN_OE_O <= 1'b1;
    end else begin
      WAVE_PIN_O    <= port5[P5_OUT_BIT];
      WAVE_PIN_OE_O <= wave_reg[WAV_OPIN];
    end
  end

  // ***********************************************************
  // Pin synchronisers: change counted when stages 2 and 3 agree
  // ***********************************************************
  localparam int NSYNC = 20;
  logic [NSYNC-1:0] s1, s2, s3;
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
    end else begin
      s1 <= {P68_PIN_I, P5_PIN_I};
      s2 <= s1;
      s3 <= s2;
    end
  end

  // A glitch that reaches stage 2 alone never counts as a change
  logic [NSYNC-1:0] pin_q;
  logic [NSYNC-1:0] settled;
  logic [NSYNC-1:0] pin_chg;
  assign settled = ~(s2 ^ s3);
  assign pin_chg = settled & (s3 ^ pin_q);
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      pin_q <= '0;
    end else begin
      pin_q <= (settled & s3) | (~settled & pin_q);
    end
  end

  // timer input pin routed to main timer clock
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      TIMER_CLK_O    <= 1'b0;
      TIMER_IN_SEL_O <= 1'b0;
    end else begin
      TIMER_CLK_O    <= wave_reg[WAV_TIN] && pin_q[WAV_TIN];
      TIMER_IN_SEL_O <= wave_reg[WAV_TIN];
    end
  end

  // ***********************************************************
  // Interrupt flags
  // ***********************************************************
  always_comb begin
    ev = 8'h00;
    ev[FLG_PCHG] = |pin_chg[NSYNC-1:4];
    ev[FLG_TMR0 +: NUM_TMR] = tmr_uf;
    // falling edge on enabled irq pins
    ev[FLG_EXTA] = wave_reg[WAV_EXTA] && pin_chg[0] && !s3[0];
    ev[FLG_EXTB] = wave_reg[WAV_EXTB] && pin_chg[1] && !s3[1];
    ev[FLG_MAIN] = MAIN_TIMER_OVF_I;
  end

  always_comb begin
    next_flags = flags;
    if (wr_go && hit(wr_addr, ADDR_FLAGS)) begin
      next_flags = flags & PWDATA_I[7:0];
    end
    next_flags = next_flags | ev;
  end

  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      flags <= RST_BYTE;
    end else begin
      flags <= next_flags;
    end
  end

  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      IRQ_O <= 1'b0;
    end else begin
      IRQ_O <= |(next_flags & mask);
    end
  end
endmodule
`default_nettype wire

// ===== tb/iptc_chk.sv
`default_nettype none
module iptc_chk
  import iptc_pkg::*;
(
  // Clock and reset
  input wire logic              CLK_I,
  input wire logic              ARST_N_I,
  // Bus request
  input wire logic              PSEL_I,
  input wire logic              PENABLE_I,
  input wire logic              PWRITE_I,
  input wire logic [ADDR_W-1:0] PADDR_I,
  // Responses and pins
  input wire logic [31:0]       PRDATA_O,
  input wire logic              PREADY_O,
  input wire logic              PSLVERR_O,
  input wire logic              TIMER_CLK_O,
  input wire logic              TIMER_IN_SEL_O
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****************
  // Bus phases
  // ****************
  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (!ARST_N_I);
  sequence s_setup;
    PSEL_I && !PENABLE_I;
  endsequence
  sequence s_rd;
    PSEL_I && PENABLE_I && PREADY_O && !PWRITE_I;
  endsequence
  a_ready_after_setup: assert property (s_setup |=> PREADY_O)
    else $error("ready missing after setup");
  a_ready_one_cycle: assert property (PREADY_O |=> !PREADY_O)
    else $error("ready longer than one cycle");
  a_ready_when_idle: assert property (!PSEL_I |-> !PREADY_O)
    else $error("ready without select");
  a_err_misaligned: assert property (PSEL_I && PENABLE_I && PREADY_O
    && (PADDR_I[1:0] != 2'b00) |-> PSLVERR_O) else $error("misaligned not refused");
  a_err_read_zero: assert property (s_rd ##0 PSLVERR_O |-> PRDATA_O == 32'h0)
    else $error("refused read not zero");
  a_rdata_upper: assert property (s_rd |-> PRDATA_O[31:8] == 24'h0)
    else $error("read data upper bits set");
  a_run_unused: assert property (s_rd ##0 (PADDR_I == ADDR_RUN) |->
    PRDATA_O[7:4] == 4'h0) else $error("run unused bits set");
  a_wave_unused: assert property (s_rd ##0 (PADDR_I == ADDR_WAVE) |->
    !PRDATA_O[4]) else $error("wave unused bit set");
  a_tin_gated: assert property (!TIMER_IN_SEL_O && !$past(TIMER_IN_SEL_O)
    |-> !TIMER_CLK_O) else $error("timer clock without function");
endmodule
bind iptc_top iptc_chk i_iptc_chk (
  .CLK_I(CLK_I), .ARST_N_I(ARST_N_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I),
  .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O),
  .PSLVERR_O(PSLVERR_O), .TIMER_CLK_O(TIMER_CLK_O), .TIMER_IN_SEL_O(TIMER_IN_SEL_O)
);
`default_nettype wire

// ===== tb/iptc_ir_load.sv
`default_nettype none
module iptc_ir_load (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        arst_n_i,
  // Emitter drive
  input  wire logic        pin_i,
  input  wire logic        oe_i,
  output logic      [15:0] pulses_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic last;
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      last     <= 1'b0;
      pulses_o <= 16'h0;
    end else begin
      last <= pin_i & oe_i;
      if (pin_i && oe_i && !last) begin
        pulses_o <= pulses_o + 16'h1;
      end
    end
  end
endmodule
`default_nettype wire

// ===== tb/iptc_top_tb.sv
`default_nettype none
module iptc_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import iptc_pkg::*;
  logic              clk;
  logic              arst_n;
  logic              psel;
  logic              penable;
  logic              pwrite;
  logic [ADDR_W-1:0] paddr;
  logic [31:0]       pwdata;
  logic [31:0]       prdata;
  logic              pready;
  logic              pslverr;
  logic [3:0]        p5_pin;
  logic [15:0]       p68_pin;
  logic              ovf;
  logic              wave_pin;
  logic              wave_oe;
  logic              tclk;
  logic              tsel;
  logic              irq;
  logic [15:0]       pulses;
  logic [15:0]       p0;
  logic [31:0]       q;
  logic              e;
  logic [7:0]        fb;
  logic [7:0]        mode [3];
  int                cnt [3];
  int                mismatches;
  int                checks;
  iptc_top i_iptc_top (
    .CLK_I(clk), .ARST_N_I(arst_n), .PSEL_I(psel), .PENABLE_I(penable),
    .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
    .PREADY_O(pready), .PSLVERR_O(pslverr), .P5_PIN_I(p5_pin), .P68_PIN_I(p68_pin),
    .MAIN_TIMER_OVF_I(ovf), .WAVE_PIN_O(wave_pin), .WAVE_PIN_OE_O(wave_oe),
    .TIMER_CLK_O(tclk), .TIMER_IN_SEL_O(tsel), .IRQ_O(irq)
  );
  iptc_ir_load i_iptc_ir_load (
    .clk_i(clk), .arst_n_i(arst_n), .pin_i(wave_pin), .oe_i(wave_oe), .pulses_o(pulses)
  );
  // ****************
  // Bus and compare tasks
  // ****************
  task automatic apb(input logic [ADDR_W-1:0] a, input logic w, input logic [7:0] d);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= {24'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    checks++;
    if (g !== x) begin
      mismatches++;
      $display("mismatch %s expected %0h seen %0h", nm, x, g);
    end
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    apb(a, 1'b1, d);
  endtask
  task automatic rdc(input string nm, input logic [ADDR_W-1:0] a, input logic [7:0] x);
    apb(a, 1'b0, 8'h00);
    chk(nm, {24'h0, x}, q);
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Generous bound: the whole sequence needs about 600 cycles
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    $display("mismatch watchdog expected finish seen hang");
    end_sim();
  end
  // ****************
  // Test sequence
  // ****************
  initial begin
    {arst_n, psel, penable, pwrite, ovf} = 5'h0;
    paddr = '0;
    pwdata = 32'h0;
    p5_pin = 4'hF;
    p68_pin = 16'h0;
    mismatches = 0;
    checks = 0;
    mode = '{8'h88, 8'hC8, 8'hA8};
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    rdc("run", ADDR_RUN, RST_BYTE);
    rdc("flags", ADDR_FLAGS, RST_BYTE);
    wr(ADDR_RUN, 8'h5F);
    rdc("run_mask", ADDR_RUN, RUN_WMASK);
    wr(ADDR_RUN, 8'h00);
    wr(ADDR_FLAGS, 8'h00);
    apb(12'hFFC, 1'b0, 8'h00);
    chk("unmapped_err", 32'h1, {31'h0, e});
    apb(ADDR_RUN + 12'h1, 1'b0, 8'h00);
    chk("misaligned_err", 32'h1, {31'h0, e});
    $display("test registers done");
    wr(ADDR_SCALE, 8'h01);
    for (int i = 0; i < NUM_TMR; i++) begin
      fb = 8'(1 << (FLG_TMR0 + i));
      wr(ADDR_PRE0 + ADDR_W'(4 * i), 8'h03);
      wr(ADDR_MASK, fb);
      wr(ADDR_RUN, 8'(1 << i));
      repeat (12) @(posedge clk);
      rdc("tmr_flag", ADDR_FLAGS, fb);
      chk("irq", 32'h1, {31'h0, irq});
      wr(ADDR_FLAGS, 8'h00);
      repeat (8) @(posedge clk);
      rdc("reload", ADDR_FLAGS, fb);
      wr(ADDR_RUN, 8'h00);
      wr(ADDR_FLAGS, 8'h00);
      repeat (20) @(posedge clk);
      rdc("held", ADDR_FLAGS, 8'h00);
    end
    $display("test timers done");
    ovf <= 1'b1;
    @(posedge clk);
    ovf <= 1'b0;
    wr(ADDR_FLAGS, 8'hFF);
    rdc("ovf", ADDR_FLAGS, 8'(1 << FLG_MAIN));
    chk("irq_masked", 32'h0, {31'h0, irq});
    wr(ADDR_FLAGS, 8'h00);
    rdc("cleared", ADDR_FLAGS, 8'h00);
    p68_pin <= 16'h0100;
    repeat (6) @(posedge clk);
    rdc("pin_chg", ADDR_FLAGS, 8'(1 << FLG_PCHG));
    wr(ADDR_FLAGS, 8'h00);
    for (int j = 0; j < 2; j++) begin
      wr(ADDR_WAVE, 8'(1 << (WAV_EXTA + j)));
      p5_pin[j] <= 1'b0;
      repeat (8) @(posedge clk);
      rdc("ext_irq", ADDR_FLAGS, 8'(1 << (FLG_EXTA + j)));
      p5_pin[j] <= 1'b1;
      repeat (6) @(posedge clk);
      wr(ADDR_FLAGS, 8'h00);
    end
    $display("test events done");
    wr(ADDR_WAVE, 8'(1 << WAV_TIN));
    repeat (6) @(posedge clk);
    chk("tin_sel", 32'h1, {31'h0, tsel});
    chk("tclk_hi", 32'h1, {31'h0, tclk});
    p5_pin[2] <= 1'b0;
    repeat (6) @(posedge clk);
    chk("tclk_lo", 32'h0, {31'h0, tclk});
    wr(ADDR_WAVE, 8'(1 << WAV_OPIN));
    wr(ADDR_PORT5, 8'h80);
    repeat (2) @(posedge clk);
    chk("oe", 32'h1, {31'h0, wave_oe});
    chk("pin_hi", 32'h1, {31'h0, wave_pin});
    wr(ADDR_PORT5, 8'h00);
    repeat (2) @(posedge clk);
    chk("pin_lo", 32'h0, {31'h0, wave_pin});
    wr(ADDR_PRE0 + 12'h4, 8'h00);
    wr(ADDR_PRE0 + 12'h8, 8'h02);
    wr(ADDR_PRE0 + 12'hC, 8'h02);
    for (int m = 0; m < 3; m++) begin
      wr(ADDR_RUN, (m == 2) ? 8'h08 : 8'h0F);
      wr(ADDR_WAVE, mode[m]);
      p0 = pulses;
      repeat (60) @(posedge clk);
      cnt[m] = int'(pulses - p0);
    end
    chk("pwm_edges", 32'h1, {31'h0, cnt[0] > 0});
    chk("ir_edges", 32'h1, {31'h0, cnt[1] > cnt[0]});
    chk("low_only", 32'h1, {31'h0, cnt[2] > 0});
    $display("test waveform done");
    end_sim();
  end
endmodule
`default_nettype wire
